// file: fifo_level_defs.svh
// Register offsets, field positions, reset values and sizes of the FIFO register block
`ifndef FIFO_LEVEL_DEFS_SVH
`define FIFO_LEVEL_DEFS_SVH
`define ADDR_FIFO_SETUP 7'h04
`define ADDR_FIFO_THRESHOLD 7'h03
`define ADDR_FIFO_FILL_COUNT 7'h04
`define ADDR_FIFO_DATA_PORT 7'h05
`define ADDR_INTERRUPT_REQUEST_0 7'h06
`define ADDR_INTERRUPT_REQUEST_1 7'h07
`define ADDR_SETUP_REG 7'h02
`define BIT_DEPTH_SELECT 7
`define BIT_NEAR_FULL 6
`define BIT_NEAR_EMPTY 5
`define BIT_FLUSH 4
`define BIT_THRESHOLD_MSB 2
`define BIT_IRQ_SET 7
`define DEPTH_LARGE 10'h0200
`define DEPTH_SMALL 10'h00ff
`define RESET_THRESHOLD 8'h00
`define RESET_FILL_COUNT 10'h0000
`define RESET_SETUP 8'h00
`define RESET_IRQ 7'h00
`endif

// file: fifo_level_pkg.sv
// Types shared by the FIFO register block
package fifo_level_pkg;
    // One host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    // Read answer of one access
    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } reg_rsp_t;
    // Byte stream from host data port writes
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;
    typedef enum logic [1:0] {
        BUF_EMPTY,
        BUF_ONE,
        BUF_TWO
    } buf_state_t;
endpackage

// file: fifo_level_and_irq_modify.sv
// FIFO data port, threshold and fill count logic with set/clear interrupt request registers
`timescale 1ns/100ps
`include "fifo_level_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Eight-bit threshold, ninth bit from setup register in 512-byte mode.
// - Near-empty flag is 1 when fill count is at or below threshold.
// - Near-full flag is 1 when depth minus fill count is at or below threshold.
// - Depth is 255 when depth select is 1, 512 when 0.
// - Fill count readable, low eight bits reset to zero.
// - In 512-byte mode upper fill count bits come from setup register.
// - Extension bits only count when 512-byte depth is selected.
// - Data port write pushes and increments count; read pops and decrements.
// - Data port accesses do not advance the host address pointer.
// - Threshold, fill count and data port sit at consecutive addresses.
// - Written ones set flags when bit 7 is 1, else clear them.
// - Flush bit empties the FIFO and always reads as zero.
module fifo_level_and_irq_modify
#(
    parameter int ADDR_W = 7,
    parameter int DEPTH_MAX = 512
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire fifo_level_pkg::reg_req_t host_req,
    output fifo_level_pkg::reg_rsp_t host_rsp,
    output logic addr_hold,
    output logic push_ready,
    input wire logic [6:0] interrupt_request_0_events,
    input wire logic [6:0] interrupt_request_1_events,
    output logic [6:0] interrupt_request_0_flags,
    output logic [6:0] interrupt_request_1_flags,
    output logic near_full_flag,
    output logic near_empty_flag,
    output logic [9:0] fill_count
);
    import fifo_level_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage and state
    logic [7:0] mem [0:DEPTH_MAX-1];
    logic [8:0] wr_ptr_ff, nxt_wr_ptr;
    logic [8:0] rd_ptr_ff, nxt_rd_ptr;
    logic [9:0] count_ff, nxt_count;
    logic [7:0] threshold_ff, nxt_threshold;
    logic depth_select_ff, nxt_depth_select;
    logic threshold_msb_extension_ff, nxt_threshold_msb_extension;
    logic [6:0] interrupt_request_0_ff, nxt_interrupt_request_0;
    logic [6:0] interrupt_request_1_ff, nxt_interrupt_request_1;
    reg_rsp_t rsp_ff, nxt_rsp;
    logic [9:0] depth;
    logic [8:0] threshold_eff;
    logic full;
    logic empty;
    logic do_push;
    logic do_pop;
    logic flush;
    logic [7:0] setup_rd;

    // Two-entry skid buffer between the host write strobe and the array
    byte_beat_t skid_ff [0:1];
    byte_beat_t nxt_skid [0:1];
    buf_state_t buf_ff, nxt_buf;
    logic in_valid;
    logic out_valid;
    logic out_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Derived levels
    always_comb
    begin
        depth = depth_select_ff ? `DEPTH_SMALL : `DEPTH_LARGE;
        // Extension bit ignored in 255-byte mode
        threshold_eff = {threshold_msb_extension_ff & ~depth_select_ff, threshold_ff};
        full = (count_ff >= depth);
        empty = (count_ff == `RESET_FILL_COUNT);
        near_empty_flag = (count_ff <= {1'b0, threshold_eff});
        near_full_flag = ((depth - count_ff) <= {1'b0, threshold_eff});
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host decode
    always_comb
    begin
        in_valid = host_req.wr && host_req.addr == `ADDR_FIFO_DATA_PORT;
        flush = host_req.wr && host_req.addr == `ADDR_SETUP_REG && host_req.wdata[`BIT_FLUSH];
        // Pop only a stored byte, never past empty
        do_pop = host_req.rd && host_req.addr == `ADDR_FIFO_DATA_PORT && !empty && !flush;
        out_valid = (buf_ff != BUF_EMPTY);
        // Push stalls while the array is full or a pop uses the port this cycle
        out_ready = !full && !do_pop && !flush;
        do_push = out_valid && out_ready;
        push_ready = (buf_ff != BUF_TWO);
        addr_hold = (host_req.wr || host_req.rd) && host_req.addr == `ADDR_FIFO_DATA_PORT;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Skid buffer next state
    always_comb
    begin
        nxt_skid[0] = skid_ff[0];
        nxt_skid[1] = skid_ff[1];
        nxt_buf = buf_ff;
        if (flush)
        begin
            nxt_buf = BUF_EMPTY;
        end
        else
        begin
            case (buf_ff)
                BUF_EMPTY:
                begin
                    if (in_valid)
                    begin
                        nxt_skid[0] = '{valid: 1'b1, data: host_req.wdata};
                        nxt_buf = BUF_ONE;
                    end
                end
                BUF_ONE:
                begin
                    if (in_valid && do_push)
                    begin
                        nxt_skid[0] = '{valid: 1'b1, data: host_req.wdata};
                    end
                    else if (in_valid)
                    begin
                        nxt_skid[1] = '{valid: 1'b1, data: host_req.wdata};
                        nxt_buf = BUF_TWO;
                    end
                    else if (do_push)
                    begin
                        nxt_buf = BUF_EMPTY;
                    end
                end
                BUF_TWO:
                begin
                    // Input refused here; push_ready is low
                    if (do_push)
                    begin
                        nxt_skid[0] = skid_ff[1];
                        nxt_buf = BUF_ONE;
                    end
                end
                default:
                begin
                    nxt_buf = BUF_EMPTY;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // FIFO pointers, count and registers next state
    always_comb
    begin
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_count = count_ff;
        nxt_threshold = threshold_ff;
        nxt_depth_select = depth_select_ff;
        nxt_threshold_msb_extension = threshold_msb_extension_ff;
        if (flush)
        begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_count = `RESET_FILL_COUNT;
        end
        else
        begin
            if (do_push)
            begin
                nxt_wr_ptr = (wr_ptr_ff + 9'd1 == depth[8:0] && depth_select_ff) ? 9'd0 : wr_ptr_ff + 9'd1;
                nxt_count = count_ff + 10'd1;
            end
            if (do_pop)
            begin
                nxt_rd_ptr = (rd_ptr_ff + 9'd1 == depth[8:0] && depth_select_ff) ? 9'd0 : rd_ptr_ff + 9'd1;
                nxt_count = count_ff - 10'd1;
            end
        end
        if (host_req.wr && host_req.addr == `ADDR_FIFO_THRESHOLD)
        begin
            nxt_threshold = host_req.wdata;
        end
        if (host_req.wr && host_req.addr == `ADDR_SETUP_REG)
        begin
            nxt_depth_select = host_req.wdata[`BIT_DEPTH_SELECT];
            nxt_threshold_msb_extension = host_req.wdata[`BIT_THRESHOLD_MSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request flags: hardware events win over a software clear
    always_comb
    begin
        nxt_interrupt_request_0 = interrupt_request_0_ff;
        nxt_interrupt_request_1 = interrupt_request_1_ff;
        if (host_req.wr && host_req.addr == `ADDR_INTERRUPT_REQUEST_0)
        begin
            nxt_interrupt_request_0 = host_req.wdata[`BIT_IRQ_SET] ? (interrupt_request_0_ff | host_req.wdata[6:0])
                                                  : (interrupt_request_0_ff & ~host_req.wdata[6:0]);
        end
        if (host_req.wr && host_req.addr == `ADDR_INTERRUPT_REQUEST_1)
        begin
            nxt_interrupt_request_1 = host_req.wdata[`BIT_IRQ_SET] ? (interrupt_request_1_ff | host_req.wdata[6:0])
                                                  : (interrupt_request_1_ff & ~host_req.wdata[6:0]);
        end
        nxt_interrupt_request_0 = nxt_interrupt_request_0 | interrupt_request_0_events;
        nxt_interrupt_request_1 = nxt_interrupt_request_1 | interrupt_request_1_events;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read answer, one cycle after the read strobe
    always_comb
    begin
        // Flush bit always reads zero; extension bits only meaningful in 512 mode
        setup_rd = {depth_select_ff, near_full_flag, near_empty_flag, 1'b0, 1'b0,
                    threshold_msb_extension_ff, depth_select_ff ? 2'b00 : count_ff[9:8]};
        nxt_rsp = '{valid: host_req.rd, rdata: 8'h00};
        case (host_req.addr)
            `ADDR_SETUP_REG: nxt_rsp.rdata = setup_rd;
            `ADDR_FIFO_THRESHOLD: nxt_rsp.rdata = threshold_ff;
            `ADDR_FIFO_FILL_COUNT: nxt_rsp.rdata = count_ff[7:0];
            `ADDR_FIFO_DATA_PORT: nxt_rsp.rdata = empty ? 8'h00 : mem[rd_ptr_ff];
            `ADDR_INTERRUPT_REQUEST_0: nxt_rsp.rdata = {1'b0, interrupt_request_0_ff};
            `ADDR_INTERRUPT_REQUEST_1: nxt_rsp.rdata = {1'b0, interrupt_request_1_ff};
            default: nxt_rsp.rdata = 8'h00;
        endcase
        if (!host_req.rd)
        begin
            nxt_rsp.rdata = rsp_ff.rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array write; storage needs no reset
    always_ff @(posedge sys_clk)
    begin
        if (do_push)
        begin
            mem[wr_ptr_ff] <= skid_ff[0].data;
        end
    end

    // State registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= `RESET_FILL_COUNT;
            threshold_ff <= `RESET_THRESHOLD;
            depth_select_ff <= 1'b0;
            threshold_msb_extension_ff <= 1'b0;
            interrupt_request_0_ff <= `RESET_IRQ;
            interrupt_request_1_ff <= `RESET_IRQ;
            rsp_ff <= '0;
            buf_ff <= BUF_EMPTY;
            skid_ff[0] <= '0;
            skid_ff[1] <= '0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            threshold_ff <= nxt_threshold;
            depth_select_ff <= nxt_depth_select;
            threshold_msb_extension_ff <= nxt_threshold_msb_extension;
            interrupt_request_0_ff <= nxt_interrupt_request_0;
            interrupt_request_1_ff <= nxt_interrupt_request_1;
            rsp_ff <= nxt_rsp;
            buf_ff <= nxt_buf;
            skid_ff[0] <= nxt_skid[0];
            skid_ff[1] <= nxt_skid[1];
        end
    end

    assign host_rsp = rsp_ff;
    assign interrupt_request_0_flags = interrupt_request_0_ff;
    assign interrupt_request_1_flags = interrupt_request_1_ff;
    assign fill_count = count_ff;
endmodule

// file: fifo_level_and_irq_modify_assertions.sv
// Port assertions for the FIFO register block
`timescale 1ns/100ps
module fifo_level_and_irq_modify_assertions
#(
    parameter int DEPTH_MAX = 512
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire fifo_level_pkg::reg_req_t host_req,
    input wire fifo_level_pkg::reg_rsp_t host_rsp,
    input wire logic addr_hold,
    input wire logic [6:0] interrupt_request_0_events,
    input wire logic [6:0] interrupt_request_0_flags,
    input wire logic near_empty_flag,
    input wire logic [9:0] fill_count
);
    import fifo_level_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // Pop of a non-empty port, write to request register 0 and flush write to the setup register
    sequence s_pop;
        host_req.rd && host_req.addr == 7'h05 && fill_count != 10'h000;
    endsequence
    sequence s_irq;
        host_req.wr && host_req.addr == 7'h06;
    endsequence
    sequence s_flush;
        host_req.wr && host_req.addr == 7'h02 && host_req.wdata[4];
    endsequence
    // Clear is only checked without events, since a same-cycle event wins
    property p_rsp; host_req.rd |=> host_rsp.valid; endproperty
    property p_quiet; !host_req.rd |=> !host_rsp.valid; endproperty
    property p_hold; host_req.wr || host_req.rd |-> addr_hold == (host_req.addr == 7'h05); endproperty
    property p_pop; s_pop |=> fill_count == $past(fill_count) - 10'h001; endproperty
    property p_set; s_irq ##0 host_req.wdata[7] |=> (interrupt_request_0_flags & $past(host_req.wdata[6:0])) == $past(host_req.wdata[6:0]);
    endproperty
    property p_clr; s_irq ##0 (!host_req.wdata[7] && interrupt_request_0_events == 7'h00) |=> (interrupt_request_0_flags & $past(host_req.wdata[6:0])) == 7'h00;
    endproperty
    property p_keep; s_irq ##0 (interrupt_request_0_events == 7'h00) |=> (interrupt_request_0_flags & ~$past(host_req.wdata[6:0])) == ($past(interrupt_request_0_flags) & ~$past(host_req.wdata[6:0]));
    endproperty
    property p_empty; fill_count == 10'h000 |-> near_empty_flag; endproperty
    property p_max; int'(fill_count) <= DEPTH_MAX; endproperty
    // A flush drops every stored byte in the very next cycle
    property p_flush; s_flush |=> fill_count == 10'h000; endproperty
    a_rsp: assert property (p_rsp) else $error("read got no answer");
    a_quiet: assert property (p_quiet) else $error("answer without read");
    a_hold: assert property (p_hold) else $error("address hold wrong");
    a_pop: assert property (p_pop) else $error("pop count wrong");
    a_set: assert property (p_set) else $error("flag not set");
    a_clr: assert property (p_clr) else $error("flag not cleared");
    a_keep: assert property (p_keep) else $error("unwritten flag moved");
    a_empty: assert property (p_empty) else $error("near empty missing");
    a_max: assert property (p_max) else $error("count above depth");
    a_flush: assert property (p_flush) else $error("flush left bytes");
endmodule
bind fifo_level_and_irq_modify fifo_level_and_irq_modify_assertions #(.DEPTH_MAX(DEPTH_MAX)) chk_i
(
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .host_req(host_req),
    .host_rsp(host_rsp),
    .addr_hold(addr_hold),
    .interrupt_request_0_events(interrupt_request_0_events),
    .interrupt_request_0_flags(interrupt_request_0_flags),
    .near_empty_flag(near_empty_flag),
    .fill_count(fill_count)
);

// file: host_model.sv
// Host controller model with an auto-advancing register address pointer
`timescale 1ns/100ps
module host_model
(
    input wire logic sys_clk,
    input wire logic addr_hold,
    output fifo_level_pkg::reg_req_t host_req
);
    import fifo_level_pkg::*;
    logic [6:0] ptr;
    initial
    begin
        host_req = '0;
        ptr = 7'h00;
    end
    ////////////////////////////////////////
    // One strobe cycle; idle fields flip so stale values are never trusted
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        host_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        ptr = addr_hold ? a : a + 7'h01;
        #1;
        host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// file: testbench.sv
// Self-checking testbench for the FIFO register block
`timescale 1ns/100ps
module testbench;
    import fifo_level_pkg::*;
    logic sys_clk, rst_n, addr_hold, push_ready, near_full_flag, near_empty_flag;
    logic [6:0] interrupt_request_0_events, interrupt_request_1_events, interrupt_request_0_flags, interrupt_request_1_flags;
    logic [9:0] fill_count;
    reg_req_t host_req;
    reg_rsp_t host_rsp;
    logic [7:0] exp_q[$];
    logic [7:0] data_q[$];
    logic [7:0] b;
    int n_fail, checks_done, i;
    fifo_level_and_irq_modify fifo_level_and_irq_modify_i (.sys_clk(sys_clk), .rst_n(rst_n), .host_req(host_req),
        .host_rsp(host_rsp), .addr_hold(addr_hold), .push_ready(push_ready), .interrupt_request_0_events(interrupt_request_0_events),
        .interrupt_request_1_events(interrupt_request_1_events), .interrupt_request_0_flags(interrupt_request_0_flags), .interrupt_request_1_flags(interrupt_request_1_flags),
        .near_full_flag(near_full_flag), .near_empty_flag(near_empty_flag), .fill_count(fill_count));
    host_model host_model_i (.sys_clk(sys_clk), .addr_hold(addr_hold), .host_req(host_req));
    ////////////////////////////////////////
    // Clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_model_i.acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_model_i.acc(1'b0, a, 8'h00);
    endtask
    // Pushes take two cycles each, so the two-entry buffer backs up only once the array is full
    task automatic fill(input int n);
        for (int k = 0; k < n; k++)
        begin
            b = 8'($urandom);
            data_q.push_back(b);
            wr(7'h05, b);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    // Read answers are matched against the oldest noted expectation
    always @(posedge sys_clk)
        if (host_rsp.valid === 1'b1)
            check({2'b00, host_rsp.rdata}, {2'b00, exp_q.pop_front()});
    // Watchdog, about seventeen times the expected run
    initial
    begin
        #(40 * 20000);
        n_fail++;
        give_verdict();
    end
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        interrupt_request_0_events = 7'h00;
        interrupt_request_1_events = 7'h00;
        n_fail = 0;
        checks_done = 0;
        b = 8'($urandom(33596));
        repeat (6) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        check(fill_count, 10'h000);
        check({7'h00, near_full_flag, near_empty_flag, push_ready}, 10'h003);
        wr(7'h03, 8'h02);
        rd(7'h03, 8'h02);
        rd(7'h04, 8'h00);
        check({3'b000, host_model_i.ptr}, 10'h005);
        fill(4);
        settle();
        check(fill_count, 10'h004);
        check({9'h000, near_empty_flag}, 10'h000);
        while (data_q.size() > 0)
            rd(7'h05, data_q.pop_front());
        check({3'b000, host_model_i.ptr}, 10'h005);
        rd(7'h05, 8'h00);
        settle();
        check(fill_count, 10'h000);
        // Small depth: overfill, extension bit ignored, then flush
        wr(7'h02, 8'h84);
        fill(258);
        settle();
        check(fill_count, 10'h0ff);
        check({9'h000, push_ready}, 10'h000);
        rd(7'h02, 8'hc4);
        wr(7'h02, 8'h94);
        settle();
        check(fill_count, 10'h000);
        check({9'h000, push_ready}, 10'h001);
        rd(7'h02, 8'ha4);
        data_q.delete();
        // Large depth with a nine-bit threshold of 0x102
        wr(7'h02, 8'h04);
        fill(300);
        settle();
        check(fill_count, 10'h12c);
        rd(7'h04, 8'h2c);
        rd(7'h02, 8'h45);
        wr(7'h02, 8'h10);
        data_q.delete();
        for (i = 6; i < 8; i++)
        begin
            wr(7'(i), 8'hff);
            wr(7'(i), 8'h05);
            wr(7'(i), 8'h00);
            rd(7'(i), 8'h7a);
            wr(7'(i), 8'h7f);
            rd(7'(i), 8'h00);
        end
        b = 8'($urandom);
        interrupt_request_0_events = b[6:0];
        interrupt_request_1_events = ~b[6:0];
        @(posedge sys_clk);
        #1;
        interrupt_request_0_events = 7'h00;
        interrupt_request_1_events = 7'h00;
        settle();
        check({3'b000, interrupt_request_0_flags}, {3'b000, b[6:0]});
        check({3'b000, interrupt_request_1_flags}, {3'b000, ~b[6:0]});
        // An event in the same cycle as a clear must keep the flag set
        interrupt_request_0_events = 7'h01;
        wr(7'h06, 8'h01);
        interrupt_request_0_events = 7'h00;
        check({3'b000, interrupt_request_0_flags}, {3'b000, b[6:1], 1'b1});
        settle();
        give_verdict();
    end
endmodule
